// *** src/exec_subset_pkg.sv ***
package exec_subset_pkg;

    // instruction codes presented on the issue port
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_CLEAR = 3'h1,
        OP_INVERT = 3'h2,
        OP_KICK = 3'h3,
        OP_COMPARE = 3'h4,
        OP_DECADJ = 3'h5,
        OP_DECSKIP = 3'h6
    } op_e;

    // execution sequencer states
    typedef enum logic {
        ST_EXEC = 1'b0,
        ST_SKIP = 1'b1
    } exec_state_e;

    // one issued instruction
    typedef struct packed {
        op_e op;
        logic [6:0] slot;
        logic toSlot;
    } inst_s;

    // datapath answer for one instruction
    typedef struct packed {
        logic [7:0] value;
        logic wrSlot;
        logic wrWork;
        logic updZero;
        logic zero;
        logic updCarry;
        logic carry;
    } alu_s;

    // register port layout, 8-bit data
    localparam logic [7:0] SLOT_LAST = 8'h7F;
    localparam logic [7:0] ADDR_WORK = 8'h80;
    localparam logic [7:0] ADDR_STATUS = 8'h81;
    localparam logic [7:0] ADDR_CTRL = 8'h82;
    localparam logic [7:0] ADDR_WDOG = 8'h83;
    localparam logic [7:0] ADDR_DIV = 8'h84;

    // status field positions
    localparam int ST_CARRY_BIT = 0;
    localparam int ST_ZERO_BIT = 1;
    localparam int ST_PD_BIT = 2;
    localparam int ST_TO_BIT = 3;
    // control field position: divider feeds the watchdog
    localparam int CTRL_DIV_WDOG_BIT = 0;

    // reset values
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [3:0] STATUS_RESET = 4'hC;
    localparam logic CTRL_RESET = 1'b1;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // decimal adjust constants
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
    localparam logic [8:0] BCD_LOW_FIX = 9'h006;
    localparam logic [8:0] BCD_HIGH_FIX = 9'h060;

endpackage

// *** src/exec_alu.sv ***
`timescale 1ns/1ps
module exec_alu (
    // operation and operands
    input wire exec_subset_pkg::inst_s inst,
    input wire logic [7:0] slotValue,
    input wire logic [7:0] workValue,
    input wire logic carryIn,
    // result
    output exec_subset_pkg::alu_s res
);
    import exec_subset_pkg::*;

    logic [8:0] diff;
    logic [8:0] lowSum;
    logic [8:0] fullSum;
    logic lowAdj;
    logic highAdj;

    // compare subtraction and decimal adjust terms
    always_comb begin
        diff = {1'b0, slotValue} - {1'b0, workValue};
        lowAdj = workValue[3:0] > BCD_MAX_DIGIT;
        lowSum = {1'b0, workValue} + (lowAdj ? BCD_LOW_FIX : 9'h000);
        // carry out of the low fix can itself push the high digit over nine
        highAdj = (lowSum[7:4] > BCD_MAX_DIGIT) || carryIn || lowSum[8];
        fullSum = lowSum + (highAdj ? BCD_HIGH_FIX : 9'h000);
    end

    // per-operation result and flag effects
    always_comb begin
        res = '0;
        case (inst.op)
            OP_CLEAR: begin
                res.value = 8'h00;
                res.wrSlot = 1'b1;
                res.updZero = 1'b1;
                res.zero = 1'b1;
            end
            OP_INVERT: begin
                res.value = ~slotValue;
                res.wrSlot = inst.toSlot;
                res.wrWork = !inst.toSlot;
                res.updZero = 1'b1;
                res.zero = (~slotValue) == 8'h00;
            end
            OP_COMPARE: begin
                // difference is dropped, only flags move
                res.updZero = 1'b1;
                res.zero = diff[7:0] == 8'h00;
                res.updCarry = 1'b1;
                res.carry = !diff[8];
            end
            OP_DECADJ: begin
                res.value = fullSum[7:0];
                res.wrWork = 1'b1;
                res.updCarry = 1'b1;
                res.carry = highAdj;
            end
            OP_DECSKIP: begin
                res.value = slotValue - 8'h01;
                res.wrSlot = inst.toSlot;
                res.wrWork = !inst.toSlot;
            end
            default: begin
                res = '0;
            end
        endcase
    end

endmodule // exec_alu

// *** src/mcu_instruction_exec_subset.sv ***
// Behaviour
// - clear slot to zero, set zero flag
// - invert slot into working value or slot
// - kick clears watchdog counter in one cycle
// - kick clears divider when assigned to watchdog
// - kick sets timeout and powerdown flags only
// - compare subtracts working value from slot
// - compare changes neither operand
// - decimal adjust rewrites working value, carry only
// - decrement slot into working value or slot
// - zero decrement discards next, takes two cycles
`timescale 1ns/1ps
module mcu_instruction_exec_subset (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // instruction issue
    input wire logic instValid,
    input wire exec_subset_pkg::inst_s instIn,
    output logic instReady,
    output logic discardNext,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // flag and counter view
    output logic zeroFlag,
    output logic carryFlag,
    output logic timeoutFlag,
    output logic powerdownFlag,
    output logic [7:0] watchdogCount,
    output logic [7:0] dividerCount
);
    import exec_subset_pkg::*;

    logic [7:0] slotMem [0:127];
    logic [7:0] work_q;
    logic [3:0] status_q;
    logic divToWdog_q;
    logic [7:0] wdog_q;
    logic [7:0] div_q;
    logic [7:0] rdata_q;
    exec_state_e state_q;
    exec_state_e state_d;
    logic fire;
    logic [7:0] slotValue;
    logic isKick;
    logic swSlotWr;
    alu_s res;

    // an instruction is taken only while not in the discarded slot
    assign instReady = (state_q == ST_EXEC);
    assign fire = clkEn && instValid && instReady;
    assign slotValue = slotMem[instIn.slot];
    assign isKick = fire && (instIn.op == OP_KICK);
    assign swSlotWr = regWr && (regAddr <= SLOT_LAST);
    assign discardNext = (state_q == ST_SKIP);

    exec_alu u_alu (
        .inst(instIn),
        .slotValue(slotValue),
        .workValue(work_q),
        .carryIn(status_q[ST_CARRY_BIT]),
        .res(res)
    );

    // slot memory: executing instruction wins over a software write
    always_ff @(posedge ref_clk) begin
        if (clkEn) begin
            if (fire && res.wrSlot) begin
                slotMem[instIn.slot] <= res.value;
            end else if (swSlotWr) begin
                slotMem[regAddr[6:0]] <= regWdata;
            end
        end
    end

    // working value; compare never writes it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            work_q <= WORK_RESET;
        end else if (clkEn) begin
            if (fire && res.wrWork) begin
                work_q <= res.value;
            end else if (regWr && regAddr == ADDR_WORK) begin
                work_q <= regWdata;
            end
        end
    end

    // status flags: hardware updates win over a software write
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= STATUS_RESET;
        end else if (clkEn) begin
            if (regWr && regAddr == ADDR_STATUS) begin
                status_q <= regWdata[3:0];
            end
            if (fire && res.updZero) begin
                status_q[ST_ZERO_BIT] <= res.zero;
            end
            if (fire && res.updCarry) begin
                status_q[ST_CARRY_BIT] <= res.carry;
            end
            if (isKick) begin
                status_q[ST_TO_BIT] <= 1'b1;
                status_q[ST_PD_BIT] <= 1'b1;
            end
        end
    end

    // divider assignment control
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            divToWdog_q <= CTRL_RESET;
        end else if (clkEn && regWr && regAddr == ADDR_CTRL) begin
            divToWdog_q <= regWdata[CTRL_DIV_WDOG_BIT];
        end
    end

    // shared divider free-runs; only a kick while assigned clears it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= COUNT_RESET;
        end else if (clkEn) begin
            if (isKick && divToWdog_q) begin
                div_q <= COUNT_RESET;
            end else begin
                div_q <= div_q + 8'h01;
            end
        end
    end

    // watchdog counter steps on divider wrap when assigned, else each cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wdog_q <= COUNT_RESET;
        end else if (clkEn) begin
            if (isKick) begin
                wdog_q <= COUNT_RESET;
            end else if (!divToWdog_q || div_q == 8'hFF) begin
                wdog_q <= wdog_q + 8'h01;
            end
        end
    end

    // skip sequencer: one extra cycle standing in for the fetched word
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                if (fire && instIn.op == OP_DECSKIP && res.value == 8'h00) begin
                    state_d = ST_SKIP;
                end
            end
            ST_SKIP: begin
                state_d = ST_EXEC;
            end
            default: begin
                state_d = ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_EXEC;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (clkEn && regRd) begin
            if (regAddr <= SLOT_LAST) begin
                rdata_q <= slotMem[regAddr[6:0]];
            end else begin
                case (regAddr)
                    ADDR_WORK: rdata_q <= work_q;
                    ADDR_STATUS: rdata_q <= {4'h0, status_q};
                    ADDR_CTRL: rdata_q <= {7'h00, divToWdog_q};
                    ADDR_WDOG: rdata_q <= wdog_q;
                    ADDR_DIV: rdata_q <= div_q;
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // flag and counter outputs all come straight from flip-flops
    assign regRdata = rdata_q;
    assign zeroFlag = status_q[ST_ZERO_BIT];
    assign carryFlag = status_q[ST_CARRY_BIT];
    assign timeoutFlag = status_q[ST_TO_BIT];
    assign powerdownFlag = status_q[ST_PD_BIT];
    assign watchdogCount = wdog_q;
    assign dividerCount = div_q;

    // checks: every trigger but AST_SKIP_FROZEN needs the enable so a frozen cycle is excluded
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    AST_CLEAR_SLOT: assert property (
        fire && instIn.op == OP_CLEAR |=> slotMem[$past(instIn.slot)] == 8'h00 && zeroFlag)
        else $error("clear did not zero the slot and set zero");

    AST_INVERT_WORK: assert property (
        fire && instIn.op == OP_INVERT && !instIn.toSlot |=> work_q == ~$past(slotValue))
        else $error("invert did not land in working value");

    AST_KICK_COUNT: assert property (
        isKick |=> wdog_q == 8'h00 && timeoutFlag && powerdownFlag)
        else $error("kick did not clear watchdog and set flags");

    AST_KICK_DIVIDER: assert property (
        isKick && divToWdog_q |=> div_q == 8'h00)
        else $error("kick did not clear assigned divider");

    AST_KICK_UNASSIGNED: assert property (
        isKick && !divToWdog_q |=> div_q == $past(div_q) + 8'h01)
        else $error("kick disturbed unassigned divider");

    AST_COMPARE_FLAGS: assert property (
        fire && instIn.op == OP_COMPARE && !(regWr && regAddr == ADDR_STATUS)
        |=> carryFlag == ($past(slotValue) >= $past(work_q))
            && zeroFlag == ($past(slotValue) == $past(work_q)))
        else $error("compare flags wrong");

    AST_COMPARE_KEEP: assert property (
        fire && instIn.op == OP_COMPARE && !(regWr && regAddr == ADDR_WORK)
        |=> work_q == $past(work_q))
        else $error("compare changed working value");

    AST_DECADJ_ZERO: assert property (
        fire && instIn.op == OP_DECADJ && !(regWr && regAddr == ADDR_STATUS)
        |=> zeroFlag == $past(zeroFlag))
        else $error("decimal adjust touched zero flag");

    AST_SKIP_TWO: assert property (
        fire && instIn.op == OP_DECSKIP && slotValue == 8'h01
        |=> discardNext && !instReady)
        else $error("zero decrement did not discard next");

    AST_NO_SKIP: assert property (
        fire && instIn.op == OP_DECSKIP && slotValue != 8'h01 |=> !discardNext)
        else $error("nonzero decrement skipped");

    // the fetched word offered during the discard leaves no trace
    AST_SKIP_DROPS: assert property (
        discardNext && clkEn && !regWr
        |=> work_q == $past(work_q) && status_q == $past(status_q))
        else $error("discarded instruction took effect");

    // the discard lasts one enabled cycle; a frozen cycle keeps it
    AST_SKIP_ONE: assert property (
        discardNext && clkEn |=> !discardNext)
        else $error("discard lasted more than one cycle");

    AST_SKIP_FROZEN: assert property (
        discardNext && !clkEn |=> discardNext)
        else $error("discard lost while frozen");

    // decrement result lands in the chosen destination
    AST_DEC_WORK: assert property (
        fire && instIn.op == OP_DECSKIP && !instIn.toSlot
        |=> work_q == $past(slotValue) - 8'h01)
        else $error("decrement did not land in working value");

    AST_DEC_SLOT: assert property (
        fire && instIn.op == OP_DECSKIP && instIn.toSlot
        |=> slotMem[$past(instIn.slot)] == $past(slotValue) - 8'h01)
        else $error("decrement did not land in the slot");

    // decrement leaves both arithmetic flags alone, skip or not
    AST_DEC_FLAGS: assert property (
        fire && instIn.op == OP_DECSKIP && !(regWr && regAddr == ADDR_STATUS)
        |=> zeroFlag == $past(zeroFlag) && carryFlag == $past(carryFlag))
        else $error("decrement touched zero or carry");

    // invert into the slot, and its zero flag
    AST_INVERT_SLOT: assert property (
        fire && instIn.op == OP_INVERT && instIn.toSlot
        |=> slotMem[$past(instIn.slot)] == ~$past(slotValue))
        else $error("invert did not land in the slot");

    AST_INVERT_ZERO: assert property (
        fire && instIn.op == OP_INVERT |=> zeroFlag == ($past(slotValue) == 8'hFF))
        else $error("invert zero flag wrong");

    // kick leaves zero and carry alone
    AST_KICK_KEEP_FLAGS: assert property (
        isKick && !(regWr && regAddr == ADDR_STATUS)
        |=> zeroFlag == $past(zeroFlag) && carryFlag == $past(carryFlag))
        else $error("kick touched zero or carry");

    // compare leaves its slot alone unless software rewrites that slot
    AST_COMPARE_SLOT: assert property (
        fire && instIn.op == OP_COMPARE && !(swSlotWr && regAddr[6:0] == instIn.slot)
        |=> slotMem[$past(instIn.slot)] == $past(slotValue))
        else $error("compare changed its slot");

    // digits already decimal with no carry pass straight through
    AST_DECADJ_KEEP: assert property (
        fire && instIn.op == OP_DECADJ && !carryFlag
            && work_q[3:0] <= BCD_MAX_DIGIT && work_q[7:4] <= BCD_MAX_DIGIT
        |=> work_q == $past(work_q) && !carryFlag)
        else $error("decimal adjust changed a decimal value");

    // a carry out of the addition is always a decimal overflow
    AST_DECADJ_CARRY: assert property (
        fire && instIn.op == OP_DECADJ && carryFlag |=> carryFlag)
        else $error("decimal adjust lost the carry");

    // divider steps every enabled cycle unless a kick clears it
    AST_DIV_STEP: assert property (
        clkEn && !(isKick && divToWdog_q) |=> div_q == $past(div_q) + 8'h01)
        else $error("divider skipped a step");

    // an assigned watchdog moves only on divider wrap, else every cycle
    AST_WDOG_HOLD: assert property (
        clkEn && divToWdog_q && !isKick && div_q != 8'hFF |=> wdog_q == $past(wdog_q))
        else $error("assigned watchdog moved between wraps");

    AST_WDOG_STEP: assert property (
        clkEn && !divToWdog_q && !isKick |=> wdog_q == $past(wdog_q) + 8'h01)
        else $error("unassigned watchdog missed a step");

    COV_SKIP: cover property (fire && instIn.op == OP_DECSKIP ##1 discardNext);
    COV_KICK: cover property (isKick && divToWdog_q);
    COV_COMPARE_EQ: cover property (fire && instIn.op == OP_COMPARE && slotValue == work_q);
    COV_DECADJ_CARRY: cover property (fire && instIn.op == OP_DECADJ && res.carry);
    COV_FROZEN_SKIP: cover property (discardNext && !clkEn);

endmodule // mcu_instruction_exec_subset

// *** testbench/mcu_instruction_exec_subset_tb.sv ***
`timescale 1ns/1ps
module mcu_instruction_exec_subset_tb;
    import exec_subset_pkg::*;
    logic ref_clk, resetn, clkEn, instValid, instReady, discardNext;
    inst_s instIn;
    logic [7:0] regAddr, regWdata, regRdata, watchdogCount, dividerCount, divPre;
    logic regWr, regRd, zeroFlag, carryFlag, timeoutFlag, powerdownFlag;
    int mismatches = 0;
    int tests_run = 0;
    // operand tables for compare and decimal adjust
    logic [7:0] cmpSlot [3] = '{8'h34, 8'h12, 8'h05};
    logic [7:0] cmpFlags [3] = '{8'h01, 8'h03, 8'h00};
    logic [7:0] daIn [4] = '{8'h4D, 8'h9A, 8'h25, 8'h99};
    logic [7:0] daOut [4] = '{8'h53, 8'h00, 8'h85, 8'h99};
    logic [3:0] daCin = 4'b0100;
    logic [3:0] daCout = 4'b0110;

    mcu_instruction_exec_subset dut (
        .ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
        .instValid(instValid), .instIn(instIn), .instReady(instReady),
        .discardNext(discardNext), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .zeroFlag(zeroFlag),
        .carryFlag(carryFlag), .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag),
        .watchdogCount(watchdogCount), .dividerCount(dividerCount)
    );

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // four-state compare, so an unknown never matches
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    // read data appear in the cycle after the strobe and hold until the next read
    task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 check8(what, exp, regRdata);
    endtask

    // divPre keeps the divider value seen during the issue cycle
    task automatic issue(input op_e op, input logic [6:0] s, input logic t);
        @(posedge ref_clk);
        instValid <= 1'b1;
        instIn <= '{op: op, slot: s, toSlot: t};
        #1 divPre = dividerCount;
        @(posedge ref_clk);
        instValid <= 1'b0;
        #1;
    endtask

    // hang guard, far beyond the some 125 cycles the tests need
    initial begin
        #(5000 * 100);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        resetn = 1'b0;
        clkEn = 1'b1;
        instValid = 1'b0;
        instIn = '0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        divPre = 8'h00;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rdChk("status", ADDR_STATUS, {4'h0, STATUS_RESET});
        rdChk("ctrl", ADDR_CTRL, 8'h01);
        rdChk("work", ADDR_WORK, WORK_RESET);
        rdChk("unmapped", 8'h90, 8'h00);
        $display("test reset done");
        // clear the last slot
        wr(8'h7F, 8'h55);
        wr(ADDR_STATUS, 8'h00);
        issue(OP_CLEAR, 7'h7F, 1'b0);
        check8("clear zero", 8'h01, {7'h0, zeroFlag});
        rdChk("clear slot", 8'h7F, 8'h00);
        $display("test clear done");
        // invert to slot, then to working value
        wr(8'h06, 8'hA6);
        issue(OP_INVERT, 7'h06, 1'b1);
        check8("invert zero", 8'h00, {7'h0, zeroFlag});
        rdChk("invert slot", 8'h06, 8'h59);
        wr(8'h07, 8'hFF);
        issue(OP_INVERT, 7'h07, 1'b0);
        check8("invert zero", 8'h01, {7'h0, zeroFlag});
        rdChk("invert work", ADDR_WORK, 8'h00);
        rdChk("invert keep", 8'h07, 8'hFF);
        $display("test invert done");
        // kick with divider on the watchdog, then on the other timer
        wr(ADDR_STATUS, 8'h03);
        issue(OP_KICK, 7'h00, 1'b0);
        check8("kick flags", 8'h0F,
            {4'h0, timeoutFlag, powerdownFlag, zeroFlag, carryFlag});
        check8("kick wdog", 8'h00, watchdogCount);
        check8("kick div", 8'h00, dividerCount);
        rdChk("div read", ADDR_DIV, 8'h01);
        wr(ADDR_CTRL, 8'h00);
        issue(OP_KICK, 7'h00, 1'b0);
        check8("kick wdog", 8'h00, watchdogCount);
        check8("kick div kept", divPre + 8'h01, dividerCount);
        rdChk("wdog read", ADDR_WDOG, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        $display("test kick done");
        // compare above, equal and below the working value
        wr(ADDR_WORK, 8'h12);
        for (int i = 0; i < 3; i++) begin
            wr(8'h08, cmpSlot[i]);
            issue(OP_COMPARE, 7'h08, 1'b0);
            check8("compare flags", cmpFlags[i], {6'h0, zeroFlag, carryFlag});
            rdChk("compare work", ADDR_WORK, 8'h12);
            rdChk("compare slot", 8'h08, cmpSlot[i]);
        end
        issue(OP_NOP, 7'h08, 1'b1);
        rdChk("nop slot", 8'h08, 8'h05);
        $display("test compare done");
        // zero flag preset high must survive the adjust
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_WORK, daIn[i]);
            wr(ADDR_STATUS, {6'h0, 1'b1, daCin[i]});
            // the two writes stand in for the addition, nothing in between
            issue(OP_DECADJ, 7'h00, 1'b0);
            check8("adjust flags", {6'h0, 1'b1, daCout[i]},
                {6'h0, zeroFlag, carryFlag});
            rdChk("adjust work", ADDR_WORK, daOut[i]);
        end
        $display("test adjust done");
        // nonzero decrement into working value, no skip
        wr(8'h0B, 8'h03);
        issue(OP_DECSKIP, 7'h0B, 1'b0);
        check8("dec no skip", 8'h02, {6'h0, instReady, discardNext});
        rdChk("dec work", ADDR_WORK, 8'h02);
        rdChk("dec keep", 8'h0B, 8'h03);
        // zero result: the instruction offered next must be dropped
        wr(8'h09, 8'h01);
        @(posedge ref_clk);
        instValid <= 1'b1;
        instIn <= '{op: OP_DECSKIP, slot: 7'h09, toSlot: 1'b1};
        @(posedge ref_clk);
        instIn <= '{op: OP_INVERT, slot: 7'h09, toSlot: 1'b1};
        clkEn <= 1'b0;
        #1 check8("skip cycle", 8'h01, {6'h0, instReady, discardNext});
        divPre = dividerCount;
        // a frozen cycle must neither end the discard nor move the divider
        @(posedge ref_clk);
        clkEn <= 1'b1;
        #1 check8("skip frozen", 8'h01, {6'h0, instReady, discardNext});
        check8("frozen div", divPre, dividerCount);
        @(posedge ref_clk);
        instValid <= 1'b0;
        #1 check8("skip done", 8'h02, {6'h0, instReady, discardNext});
        rdChk("skip slot", 8'h09, 8'h00);
        $display("test decrement done");
        tally_and_finish();
    end
endmodule // mcu_instruction_exec_subset_tb
